// >>> rtl/rirq_defs.svh
// register offsets, field positions and reset values of the radio doorbell routing block
// assumes byte addressing with 8-bit addresses on the register port and one 32-bit word per register
`ifndef RIRQ_DEFS_SVH
`define RIRQ_DEFS_SVH

`define RIRQ_ADDR_W 8
`define RIRQ_DATA_W 32

`define RIRQ_OFS_ROUTE 8'h18
`define RIRQ_OFS_ACK 8'h1C
`define RIRQ_OFS_GPO 8'h20
`define RIRQ_OFS_STATUS 8'h24
`define RIRQ_OFS_MASK 8'h28

`define RIRQ_NUM_SRC 12
`define RIRQ_ROUTE_RESET 12'h000
`define RIRQ_VEC_FIRST 1'h0
`define RIRQ_VEC_SECOND 1'h1

`define RIRQ_BIT_TX_BUF_SWAP 11
`define RIRQ_BIT_TX_ENTRY_DONE 10
`define RIRQ_BIT_RETRANS_SENT 9
`define RIRQ_BIT_CTRL_ACK_ACK 8
`define RIRQ_BIT_CTRL_ACK_SENT 7
`define RIRQ_BIT_CTRL_SENT 6
`define RIRQ_BIT_ACK_SENT 5
`define RIRQ_BIT_TX_FINISHED 4
`define RIRQ_BIT_LAST_FG_DONE 3
`define RIRQ_BIT_FG_DONE 2
`define RIRQ_BIT_LAST_CMD_DONE 1
`define RIRQ_BIT_CMD_DONE 0

`define RIRQ_ACK_BIT 0
`define RIRQ_ACK_RESET 1'h0

`define RIRQ_GPO_LINES 4
`define RIRQ_GPO_SEL_W 4
`define RIRQ_GPO_USED_W 16
`define RIRQ_GPO_RESET 16'h0000
`define RIRQ_GPO_CODE_MODEM 4'h4
`define RIRQ_GPO_CODE_FRONT 4'h8
`define RIRQ_GPO_CODE_TIMER 4'hC

`define RIRQ_EVT_W 3
`define RIRQ_EVT_ACK 0
`define RIRQ_EVT_VEC_FIRST 1
`define RIRQ_EVT_VEC_SECOND 2
`define RIRQ_EVT_RESET 3'h0

`endif

// >>> rtl/rirq_pkg.sv
// types shared by the radio doorbell routing block
// assumes rirq_defs.svh is on the include path
`include "rirq_defs.svh"

package rirq_pkg;

  // one register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`RIRQ_ADDR_W-1:0] addr;
    logic [`RIRQ_DATA_W-1:0] wdata;
  } rirq_bus_req_t;

  // output lines offered by the four radio engines
  typedef struct packed {
    logic [3:0] timer;
    logic [3:0] front;
    logic [3:0] modem;
    logic [3:0] cmdp;
  } rirq_gpo_src_t;

  // engine group named by the two upper bits of a select code
  typedef enum logic [1:0] {
    RIRQ_GRP_CMDP = 2'h0,
    RIRQ_GRP_MODEM = 2'h1,
    RIRQ_GRP_FRONT = 2'h2,
    RIRQ_GRP_TIMER = 2'h3
  } rirq_grp_t;

endpackage

// >>> rtl/rirq_top.sv
// radio doorbell routing block: vector routing, command acknowledge flag, output line select
// assumes pending flags, enables, ack pulses and engine lines come from logic on i_clock
//
// Summary of operation
// - routing bit 0 sends its source to the first vector, 1 to the second
// - bit 11 routes transmit-buffer-swapped; read/write, resets to first vector
// - bit 10 routes transmit-queue-entry-finished; read/write, resets to first vector
// - bit 9 routes retransmission-sent; read/write, resets to first vector
// - bit 8 routes control-acknowledge-acknowledged; read/write, resets to first vector
// - bit 7 routes control-acknowledge-sent; read/write, resets to first vector
// - bit 6 routes control-frame-sent; read/write, resets to first vector
// - bit 5 routes acknowledge-frame-sent; read/write, resets to first vector
// - bit 4 routes transmit-finished; read/write, resets to first vector
// - bit 3 routes last-foreground-command-finished; read/write, resets to first vector
// - bit 2 routes foreground-command-finished; read/write, resets to first vector
// - bit 1 routes last-command-finished; read/write, resets to first vector
// - bit 0 routes command-finished; read/write, resets to first vector
// - command acknowledge flag is bit 0 at offset 1Ch, read/write, resets 0
// - bits 31-1 of the acknowledge register read zero; software writes only zero
// - output select at 20h holds four 4-bit fields, reset 0, upper bits zero
// - select codes pick command, modem, front-end or timer engine line 0-3
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
`include "rirq_defs.svh"

module rirq_top
  import rirq_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_clock_en,
  input wire rirq_bus_req_t i_bus,
  output logic [`RIRQ_DATA_W-1:0] o_rd_data,
  input wire logic [`RIRQ_NUM_SRC-1:0] i_pending_flags,
  input wire logic [`RIRQ_NUM_SRC-1:0] i_pending_enable,
  input wire logic i_cmd_ack,
  input wire rirq_gpo_src_t i_gpo_src,
  output logic o_vector_first,
  output logic o_vector_second,
  output logic [`RIRQ_GPO_LINES-1:0] o_output_lines,
  output logic o_irq
);

  logic [`RIRQ_NUM_SRC-1:0] routing;
  logic command_ack_pending;
  logic [`RIRQ_GPO_USED_W-1:0] gpo_select;
  logic [`RIRQ_EVT_W-1:0] irq_status;
  logic [`RIRQ_EVT_W-1:0] irq_mask;

  // address decode
  wire sel_route = i_bus.addr == `RIRQ_OFS_ROUTE;
  wire sel_ack = i_bus.addr == `RIRQ_OFS_ACK;
  wire sel_gpo = i_bus.addr == `RIRQ_OFS_GPO;
  wire sel_status = i_bus.addr == `RIRQ_OFS_STATUS;
  wire sel_mask = i_bus.addr == `RIRQ_OFS_MASK;
  wire wr_route = i_bus.wr && sel_route;
  wire wr_ack = i_bus.wr && sel_ack;
  wire wr_gpo = i_bus.wr && sel_gpo;
  wire wr_mask = i_bus.wr && sel_mask;
  wire rd_status = i_bus.rd && sel_status;

  // routing register
  wire [`RIRQ_NUM_SRC-1:0] next_routing = wr_route ? i_bus.wdata[`RIRQ_NUM_SRC-1:0] : routing;

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
      routing <= `RIRQ_ROUTE_RESET; // every source starts on the first vector
    else if (i_clock_en)
      routing <= next_routing;
  end

  // vector selection: a routing bit of 1 moves its source to the second vector
  wire [`RIRQ_NUM_SRC-1:0] active_src = i_pending_flags & i_pending_enable;
  wire [`RIRQ_NUM_SRC-1:0] to_second = active_src & routing;
  wire [`RIRQ_NUM_SRC-1:0] to_first = active_src & ~routing;
  wire next_vector_first = |to_first;
  wire next_vector_second = |to_second;

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      o_vector_first <= 1'b0;
      o_vector_second <= 1'b0;
    end
    else if (i_clock_en)
    begin
      o_vector_first <= next_vector_first;
      o_vector_second <= next_vector_second;
    end
  end

  // command acknowledge flag: hardware set wins over a software clear
  wire ack_wdata = i_bus.wdata[`RIRQ_ACK_BIT];
  wire next_command_ack_pending = i_cmd_ack || (wr_ack ? ack_wdata : command_ack_pending);

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
      command_ack_pending <= `RIRQ_ACK_RESET;
    else if (i_clock_en)
      command_ack_pending <= next_command_ack_pending;
  end

  // output line select register
  wire [`RIRQ_GPO_USED_W-1:0] next_gpo_select =
    wr_gpo ? i_bus.wdata[`RIRQ_GPO_USED_W-1:0] : gpo_select;

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
      gpo_select <= `RIRQ_GPO_RESET;
    else if (i_clock_en)
      gpo_select <= next_gpo_select;
  end

  // one selector per output line
  wire [`RIRQ_GPO_LINES-1:0] next_output_lines;

  generate
    for (genvar g = 0; g < `RIRQ_GPO_LINES; g++)
    begin : g_line
      rirq_line_sel rirq_line_sel_i
      (
        .i_code(gpo_select[g*`RIRQ_GPO_SEL_W +: `RIRQ_GPO_SEL_W]),
        .i_src(i_gpo_src),
        .o_line(next_output_lines[g])
      );
    end
  endgenerate

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
      o_output_lines <= '0;
    else if (i_clock_en)
      o_output_lines <= next_output_lines;
  end

  // interrupt status: sticky, cleared by a read, a new event wins over the read
  wire [`RIRQ_EVT_W-1:0] evt;
  assign evt[`RIRQ_EVT_ACK] = i_cmd_ack;
  assign evt[`RIRQ_EVT_VEC_FIRST] = next_vector_first && !o_vector_first;
  assign evt[`RIRQ_EVT_VEC_SECOND] = next_vector_second && !o_vector_second;
  wire [`RIRQ_EVT_W-1:0] next_irq_status = evt | (rd_status ? `RIRQ_EVT_RESET : irq_status);
  wire [`RIRQ_EVT_W-1:0] next_irq_mask = wr_mask ? i_bus.wdata[`RIRQ_EVT_W-1:0] : irq_mask;
  wire next_irq = |(next_irq_status & next_irq_mask);

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      irq_status <= `RIRQ_EVT_RESET;
      irq_mask <= `RIRQ_EVT_RESET;
      o_irq <= 1'b0;
    end
    else if (i_clock_en)
    begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      o_irq <= next_irq;
    end
  end

  // read mux; unmapped addresses and reserved bits read zero
  wire [`RIRQ_DATA_W-1:0] rd_route = {{(`RIRQ_DATA_W-`RIRQ_NUM_SRC){1'b0}}, routing};
  wire [`RIRQ_DATA_W-1:0] rd_ack = {{(`RIRQ_DATA_W-1){1'b0}}, command_ack_pending};
  wire [`RIRQ_DATA_W-1:0] rd_gpo = {{(`RIRQ_DATA_W-`RIRQ_GPO_USED_W){1'b0}}, gpo_select};
  wire [`RIRQ_DATA_W-1:0] rd_stat = {{(`RIRQ_DATA_W-`RIRQ_EVT_W){1'b0}}, irq_status};
  wire [`RIRQ_DATA_W-1:0] rd_mask = {{(`RIRQ_DATA_W-`RIRQ_EVT_W){1'b0}}, irq_mask};
  wire [`RIRQ_DATA_W-1:0] rd_word =
    sel_route ? rd_route :
    sel_ack ? rd_ack :
    sel_gpo ? rd_gpo :
    sel_status ? rd_stat :
    sel_mask ? rd_mask :
    '0;
  wire [`RIRQ_DATA_W-1:0] next_rd_data = i_bus.rd ? rd_word : '0;

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
      o_rd_data <= '0;
    else if (i_clock_en)
      o_rd_data <= next_rd_data;
  end

  // checks
  a_route_first: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_clock_en |=> o_vector_first == |($past(i_pending_flags & i_pending_enable & ~routing)))
    else $error("first vector does not match its routed sources");

  a_route_second: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_clock_en |=> o_vector_second == |($past(i_pending_flags & i_pending_enable & routing)))
    else $error("second vector does not match its routed sources");

  a_route_reset: assert property (@(posedge i_clock)
    !i_reset_n |=> routing == `RIRQ_ROUTE_RESET)
    else $error("routing bits not on first vector after reset");

  a_route_write: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && wr_route) |=> routing == $past(i_bus.wdata[`RIRQ_NUM_SRC-1:0]))
    else $error("routing write not stored");

  a_ack_set: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && i_cmd_ack) |=> command_ack_pending)
    else $error("acknowledge did not set the flag");

  a_ack_hold: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (command_ack_pending && i_clock_en && !(wr_ack && !ack_wdata)) |=> command_ack_pending)
    else $error("acknowledge flag dropped without a clear");

  a_ack_read: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && i_bus.rd && sel_ack) |=> o_rd_data == {31'h0, $past(command_ack_pending)})
    else $error("acknowledge register read wrong");

  a_gpo_read: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && i_bus.rd && sel_gpo) |=> o_rd_data[31:16] == 16'h0000)
    else $error("output select upper bits not zero");

  a_gpo_timer: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && gpo_select[3:0] == `RIRQ_GPO_CODE_TIMER)
      |=> o_output_lines[0] == $past(i_gpo_src.timer[0]))
    else $error("line 0 did not follow timer line 0");

  a_gpo_modem: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && gpo_select[3:0] == `RIRQ_GPO_CODE_MODEM)
      |=> o_output_lines[0] == $past(i_gpo_src.modem[0]))
    else $error("line 0 did not follow modem line 0");

  a_irq_level: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_clock_en |=> o_irq == |(irq_status & irq_mask))
    else $error("interrupt output does not follow masked status");

  a_ack_reset: assert property (@(posedge i_clock)
    !i_reset_n |=> !command_ack_pending)
    else $error("acknowledge flag not clear after reset");

  a_ack_wclear: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && wr_ack && !ack_wdata && !i_cmd_ack) |=> !command_ack_pending)
    else $error("write of zero did not clear the acknowledge flag");

  a_ack_wset: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && wr_ack && ack_wdata) |=> command_ack_pending)
    else $error("write of one did not set the acknowledge flag");

  a_ack_reserved: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && i_bus.rd && sel_ack) |=> o_rd_data[31:1] == 31'h0)
    else $error("acknowledge register reserved bits not zero");

  a_gpo_reset: assert property (@(posedge i_clock)
    !i_reset_n |=> gpo_select == `RIRQ_GPO_RESET)
    else $error("output select not zero after reset");

  a_gpo_write: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && wr_gpo) |=> gpo_select == $past(i_bus.wdata[`RIRQ_GPO_USED_W-1:0]))
    else $error("output select write not stored");

  a_gpo_cmdp: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && gpo_select[7:4] == 4'h2) |=> o_output_lines[1] == $past(i_gpo_src.cmdp[2]))
    else $error("line 1 did not follow command line 2");

  a_gpo_front: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && gpo_select[15:12] == `RIRQ_GPO_CODE_FRONT)
      |=> o_output_lines[3] == $past(i_gpo_src.front[0]))
    else $error("line 3 did not follow front-end line 0");

  a_route_read: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && i_bus.rd && sel_route) |=> o_rd_data == {20'h0, $past(routing)})
    else $error("routing register read wrong");

  a_route_hold: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && !wr_route) |=> routing == $past(routing))
    else $error("routing changed without a write");

  a_lines_reset: assert property (@(posedge i_clock)
    !i_reset_n |=> o_output_lines == '0)
    else $error("output lines not low after reset");

  a_read_idle: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && !i_bus.rd) |=> o_rd_data == '0)
    else $error("read data not zero outside a read");

  a_status_set: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && i_cmd_ack) |=> irq_status[`RIRQ_EVT_ACK])
    else $error("acknowledge event not recorded");

  a_status_clear: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && rd_status && !i_cmd_ack) |=> !irq_status[`RIRQ_EVT_ACK])
    else $error("status read did not clear the acknowledge event");

  a_status_first: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && next_vector_first && !o_vector_first) |=> irq_status[`RIRQ_EVT_VEC_FIRST])
    else $error("first vector rise not recorded");

  a_status_second: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && next_vector_second && !o_vector_second) |=> irq_status[`RIRQ_EVT_VEC_SECOND])
    else $error("second vector rise not recorded");

  a_mask_write: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && wr_mask) |=> irq_mask == $past(i_bus.wdata[`RIRQ_EVT_W-1:0]))
    else $error("mask write not stored");

  a_clock_freeze: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    !i_clock_en |=> $stable(routing) && $stable(gpo_select) && $stable(o_rd_data))
    else $error("state changed while the clock enable was low");

  c_second_vec: cover property (@(posedge i_clock) disable iff (!i_reset_n)
    wr_route ##1 o_vector_second[*2]);

  c_ack_clear: cover property (@(posedge i_clock) disable iff (!i_reset_n)
    command_ack_pending ##1 (wr_ack && !ack_wdata) ##1 !command_ack_pending);

  c_gpo_front: cover property (@(posedge i_clock) disable iff (!i_reset_n)
    gpo_select[15:12] == `RIRQ_GPO_CODE_FRONT);

  c_irq_read: cover property (@(posedge i_clock) disable iff (!i_reset_n)
    o_irq ##1 rd_status ##1 !o_irq);

  c_clock_freeze: cover property (@(posedge i_clock) disable iff (!i_reset_n)
    !i_clock_en ##1 i_clock_en);

endmodule // rirq_top

// one output line: upper two code bits pick the engine, lower two its line
module rirq_line_sel
  import rirq_pkg::*;
#(
  parameter int SEL_W = `RIRQ_GPO_SEL_W
)
(
  input wire logic [SEL_W-1:0] i_code,
  input wire rirq_gpo_src_t i_src,
  output logic o_line
);

  wire rirq_grp_t grp = rirq_grp_t'(i_code[SEL_W-1:SEL_W-2]);
  wire [1:0] idx = i_code[1:0];
  wire from_cmdp = grp == RIRQ_GRP_CMDP;
  wire from_modem = grp == RIRQ_GRP_MODEM;
  wire from_front = grp == RIRQ_GRP_FRONT;

  assign o_line =
    from_cmdp ? i_src.cmdp[idx] :
    from_modem ? i_src.modem[idx] :
    from_front ? i_src.front[idx] :
    i_src.timer[idx];

endmodule // rirq_line_sel

// >>> testbench/rirq_far_model.sv
// far-side model: the interrupt controller counting each rise of the two vectors
// assumes both vectors are synchronous to i_clock
`timescale 1ns/100ps

module rirq_far_model
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_vector_first,
  input wire logic i_vector_second,
  output logic [7:0] o_rises_first,
  output logic [7:0] o_rises_second
);
  logic last_first;
  logic last_second;

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      last_first <= 1'b0;
      last_second <= 1'b0;
      o_rises_first <= 8'h00;
      o_rises_second <= 8'h00;
    end
    else
    begin
      last_first <= i_vector_first;
      last_second <= i_vector_second;
      // an edge-triggered controller sees each new assertion once
      if (i_vector_first && !last_first)
        o_rises_first <= o_rises_first + 8'h01;
      if (i_vector_second && !last_second)
        o_rises_second <= o_rises_second + 8'h01;
    end
  end
endmodule // rirq_far_model

// >>> testbench/testbench.sv
// self-checking bench for the radio doorbell routing block
// assumes rirq_pkg, rirq_top and rirq_far_model are compiled first
`timescale 1ns/100ps
`include "rirq_defs.svh"

module testbench
  import rirq_pkg::*;
();
  logic clock;
  logic reset_n;
  logic clock_en;
  rirq_bus_req_t bus;
  logic [31:0] rd_data;
  logic [11:0] flags;
  logic [11:0] en;
  logic ack;
  rirq_gpo_src_t gpo;
  logic vf;
  logic vs;
  logic [3:0] lines;
  logic irq;
  logic [7:0] rises_f;
  logic [7:0] rises_s;
  int n_errors;
  int n_compared;

  rirq_top rirq_top_i (.i_clock(clock), .i_reset_n(reset_n), .i_clock_en(clock_en),
    .i_bus(bus), .o_rd_data(rd_data), .i_pending_flags(flags), .i_pending_enable(en),
    .i_cmd_ack(ack), .i_gpo_src(gpo), .o_vector_first(vf), .o_vector_second(vs),
    .o_output_lines(lines), .o_irq(irq));

  rirq_far_model rirq_far_model_i (.i_clock(clock), .i_reset_n(reset_n),
    .i_vector_first(vf), .i_vector_second(vs), .o_rises_first(rises_f),
    .o_rises_second(rises_s));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= {1'b1, 1'b0, a, d};
    @(posedge clock);
    bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    bus <= {1'b0, 1'b1, a, 32'h0};
    @(posedge clock);
    bus <= '0;
    #1;
    d = rd_data;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask

  task automatic pulse_ack;
    @(posedge clock);
    ack <= 1'b1;
    @(posedge clock);
    ack <= 1'b0;
    #1;
  endtask

  task complete_run;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #500000;
    n_errors++;
    complete_run();
  end

  initial
  begin
    reset_n = 1'b0;
    clock_en = 1'b1;
    bus = '0;
    flags = 12'h000;
    en = 12'h000;
    ack = 1'b0;
    gpo = 16'hA5C3;
    n_errors = 0;
    n_compared = 0;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    rdchk("route reset", `RIRQ_OFS_ROUTE, 32'h0);
    rdchk("ack reset", `RIRQ_OFS_ACK, 32'h0);
    rdchk("gpo reset", `RIRQ_OFS_GPO, 32'h0);
    rdchk("unmapped", 8'h30, 32'h0);
    wr(`RIRQ_OFS_ROUTE, 32'hFFFF_FFFF);
    rdchk("route width", `RIRQ_OFS_ROUTE, 32'h0000_0FFF);
    for (int i = 0; i < 12; i++)
    begin
      wr(`RIRQ_OFS_ROUTE, 32'h1 << i);
      rdchk("route bit", `RIRQ_OFS_ROUTE, 32'h1 << i);
      @(posedge clock);
      flags <= 12'h001 << i;
      en <= 12'h001 << i;
      tick(2);
      chk("vector second", 32'h1, {30'h0, vf, vs});
      @(posedge clock);
      en <= 12'h000;
      tick(2);
      chk("vector gated", 32'h0, {30'h0, vf, vs});
      wr(`RIRQ_OFS_ROUTE, 32'h0);
      @(posedge clock);
      en <= 12'hFFF;
      tick(2);
      chk("vector first", 32'h2, {30'h0, vf, vs});
      @(posedge clock);
      flags <= 12'h000;
      en <= 12'h000;
    end
    tick(2);
    chk("rises", 32'h0000_0C0C, {16'h0, rises_f, rises_s});
    rdchk("status vectors", `RIRQ_OFS_STATUS, 32'h6);
    pulse_ack();
    rdchk("ack set", `RIRQ_OFS_ACK, 32'h1);
    rdchk("ack held", `RIRQ_OFS_ACK, 32'h1);
    wr(`RIRQ_OFS_ACK, 32'h0);
    rdchk("ack clear", `RIRQ_OFS_ACK, 32'h0);
    wr(`RIRQ_OFS_ACK, 32'h1);
    rdchk("ack reserved", `RIRQ_OFS_ACK, 32'h1);
    wr(`RIRQ_OFS_ACK, 32'h0);
    rdchk("status ack", `RIRQ_OFS_STATUS, 32'h1);
    wr(`RIRQ_OFS_MASK, 32'h1);
    rdchk("mask", `RIRQ_OFS_MASK, 32'h1);
    pulse_ack();
    chk("irq raised", 32'h1, {31'h0, irq});
    rdchk("status", `RIRQ_OFS_STATUS, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(`RIRQ_OFS_MASK, 32'h0);
    pulse_ack();
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`RIRQ_OFS_ACK, 32'h0);
    for (int g = 0; g < 4; g++)
      for (int c = 0; c < 16; c++)
      begin
        wr(`RIRQ_OFS_GPO, 32'(c) << (4 * g));
        rdchk("gpo field", `RIRQ_OFS_GPO, 32'(c) << (4 * g));
        chk("gpo line", {31'h0, gpo[c]}, {31'h0, lines[g]});
        @(posedge clock);
        gpo <= ~gpo;
        tick(2);
        chk("gpo line inv", {31'h0, gpo[c]}, {31'h0, lines[g]});
      end
    wr(`RIRQ_OFS_GPO, 32'hFFFF_FFFF);
    rdchk("gpo width", `RIRQ_OFS_GPO, 32'h0000_FFFF);
    @(posedge clock);
    clock_en <= 1'b0;
    bus <= {1'b1, 1'b0, `RIRQ_OFS_GPO, 32'h0000_0005};
    @(posedge clock);
    clock_en <= 1'b1;
    bus <= '0;
    rdchk("gpo frozen", `RIRQ_OFS_GPO, 32'h0000_FFFF);
    wr(`RIRQ_OFS_ROUTE, 32'h0000_0FFF);
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rdchk("route after reset", `RIRQ_OFS_ROUTE, 32'h0);
    rdchk("gpo after reset", `RIRQ_OFS_GPO, 32'h0);
    complete_run();
  end
endmodule // testbench
